// File: logic/ratc_defs.svh
// constants for the right agc time constant register pair
// assumes inclusion by bare name from the package and the design modules
`ifndef RATC_DEFS_SVH
`define RATC_DEFS_SVH

// register offsets
`define RATC_ATTACK_OFS     8'h69
`define RATC_DECAY_OFS      8'h6A

// field positions, shared by both registers
`define RATC_SEL_BIT        7
`define RATC_BASE_HI        6
`define RATC_BASE_LO        5
`define RATC_MULT_HI        4
`define RATC_MULT_LO        2
`define RATC_RSVD_HI        1
`define RATC_RSVD_LO        0

// reset values
`define RATC_ATTACK_RST     8'h00
`define RATC_DECAY_RST      8'h00
`define RATC_RDATA_RST      8'h00
`define RATC_UNMAPPED_RD    8'h00

// widths of the time values, in ms
`define RATC_ATT_W          11
`define RATC_DEC_W          16

// baseline attack times, ms
`define RATC_ATT_BASE_0     11'h007
`define RATC_ATT_BASE_1     11'h008
`define RATC_ATT_BASE_2     11'h00A
`define RATC_ATT_BASE_3     11'h00B

// baseline decay times, ms
`define RATC_DEC_BASE_0     16'h0032
`define RATC_DEC_BASE_1     16'h0096
`define RATC_DEC_BASE_2     16'h00FA
`define RATC_DEC_BASE_3     16'h015E

// rate divider ratio is carried in half steps (ratio times two)
`define RATC_RATIO_W        4
`define RATC_RATIO_1_0      4'h2
`define RATC_RATIO_1_5      4'h3
`define RATC_RATIO_2_0      4'h4
`define RATC_RATIO_2_5      4'h5
`define RATC_RATIO_3_0      4'h6
`define RATC_RATIO_3_5      4'h7
`define RATC_RATIO_4_0      4'h8
`define RATC_RATIO_4_5      4'h9
`define RATC_RATIO_5_0      4'hA
`define RATC_RATIO_5_5      4'hB
`define RATC_RATIO_6_0      4'hC

// longest decay time per ratio, ms
`define RATC_CAP_4000       16'h0FA0
`define RATC_CAP_5600       16'h15E0
`define RATC_CAP_8000       16'h1F40
`define RATC_CAP_9600       16'h2580
`define RATC_CAP_11200      16'h2BC0
`define RATC_CAP_16000      16'h3E80
`define RATC_CAP_19200      16'h4B00
`define RATC_CAP_22400      16'h5780

`endif

// File: logic/ratc_pkg.sv
// types for the right agc time constant register pair
// assumes ratc_defs.svh is on the include path
`include "ratc_defs.svh"

package ratc_pkg;
   typedef logic [7:0]                  ratc_byte_t;
   typedef logic [`RATC_ATT_W-1:0]      ratc_att_ms_t;
   typedef logic [`RATC_DEC_W-1:0]      ratc_dec_ms_t;
   typedef logic [`RATC_RATIO_W-1:0]    ratc_ratio_t;
endpackage

// File: logic/ratc_cap.sv
// decay cap lookup from the codec rate divider ratio
// assumes the ratio arrives in half steps from logic on the same clock
`timescale 1ns/1ps
`include "ratc_defs.svh"

module ratc_cap (
   // ratio in
   input  wire ratc_pkg::ratc_ratio_t  ratio_x2,
   // cap out
   output ratc_pkg::ratc_dec_ms_t      cap_ms
);
   import ratc_pkg::*;

   always_comb begin
      unique case (ratio_x2)
         `RATC_RATIO_1_0 : cap_ms = `RATC_CAP_4000;
         `RATC_RATIO_1_5 : cap_ms = `RATC_CAP_5600;
         `RATC_RATIO_2_0 : cap_ms = `RATC_CAP_8000;
         `RATC_RATIO_2_5 : cap_ms = `RATC_CAP_9600;
         `RATC_RATIO_3_0,
         `RATC_RATIO_3_5 : cap_ms = `RATC_CAP_11200;
         `RATC_RATIO_4_0,
         `RATC_RATIO_4_5 : cap_ms = `RATC_CAP_16000;
         `RATC_RATIO_5_0 : cap_ms = `RATC_CAP_19200;
         `RATC_RATIO_5_5,
         `RATC_RATIO_6_0 : cap_ms = `RATC_CAP_22400;
         // codes outside the range clamp to the nearest end
         default : begin
            if (ratio_x2 < `RATC_RATIO_1_0) begin
               cap_ms = `RATC_CAP_4000;
            end else begin
               cap_ms = `RATC_CAP_22400;
            end
         end
      endcase
   end
endmodule

// File: logic/ratc_regs.sv
// right agc attack and decay time registers with effective time outputs
// assumes the control bus decoder and legacy timing logic share clk_sys
//
// Operation
// - attack select bit picks legacy timing or this register's attack fields
// - baseline attack code gives 7, 8, 10 or 11 ms
// - attack multiplier code n scales the baseline by two to the n
// - decay select bit picks legacy timing or this register's decay fields
// - baseline decay code gives 50, 150, 250 or 350 ms
// - decay multiplier code n scales the baseline by two to the n
// - decay time is capped by the selected codec rate divider ratio
`timescale 1ns/1ps
`include "ratc_defs.svh"

module ratc_regs (
   // clock and reset
   input  wire logic                   clk_sys,
   input  wire logic                   sys_rst,
   // register port
   input  wire ratc_pkg::ratc_byte_t   reg_addr,
   input  wire logic                   reg_wr_en,
   input  wire ratc_pkg::ratc_byte_t   reg_wdata,
   input  wire logic                   reg_rd_en,
   output ratc_pkg::ratc_byte_t        reg_rdata,
   output logic                        reg_rd_ack,
   // legacy timing and rate divider
   input  wire ratc_pkg::ratc_att_ms_t legacy_attack_ms,
   input  wire ratc_pkg::ratc_dec_ms_t legacy_decay_ms,
   input  wire ratc_pkg::ratc_ratio_t  codec_rate_divider_ratio,
   // effective times to the agc engine
   output ratc_pkg::ratc_att_ms_t      attack_time_ms,
   output ratc_pkg::ratc_dec_ms_t      decay_time_ms,
   output logic                        attack_src_own,
   output logic                        decay_src_own,
   output logic                        decay_capped
);
   import ratc_pkg::*;

   // ************************************************************
   // state
   // ************************************************************
   ratc_byte_t    attack_reg_r;
   ratc_byte_t    attack_reg_nxt;
   ratc_byte_t    decay_reg_r;
   ratc_byte_t    decay_reg_nxt;
   ratc_byte_t    rdata_r;
   ratc_byte_t    rdata_nxt;
   logic          rd_ack_r;
   logic          rd_ack_nxt;
   ratc_att_ms_t  attack_ms_r;
   ratc_att_ms_t  attack_ms_nxt;
   ratc_dec_ms_t  decay_ms_r;
   ratc_dec_ms_t  decay_ms_nxt;
   logic          att_own_r;
   logic          att_own_nxt;
   logic          dec_own_r;
   logic          dec_own_nxt;
   logic          capped_r;
   logic          capped_nxt;

   // ************************************************************
   // field decode
   // ************************************************************
   logic [1:0]    att_base_code;
   logic [2:0]    att_mult_code;
   logic [1:0]    dec_base_code;
   logic [2:0]    dec_mult_code;
   ratc_att_ms_t  att_base_ms;
   ratc_dec_ms_t  dec_base_ms;
   ratc_att_ms_t  att_scaled_ms;
   ratc_dec_ms_t  dec_scaled_ms;
   ratc_dec_ms_t  dec_chosen_ms;
   ratc_dec_ms_t  dec_cap_ms;

   assign att_base_code = attack_reg_r[`RATC_BASE_HI:`RATC_BASE_LO];
   assign att_mult_code = attack_reg_r[`RATC_MULT_HI:`RATC_MULT_LO];
   assign dec_base_code = decay_reg_r[`RATC_BASE_HI:`RATC_BASE_LO];
   assign dec_mult_code = decay_reg_r[`RATC_MULT_HI:`RATC_MULT_LO];

   // two-bit codes map every value, so no default arm is needed
   always_comb begin
      unique case (att_base_code)
         2'h0 : att_base_ms = `RATC_ATT_BASE_0;
         2'h1 : att_base_ms = `RATC_ATT_BASE_1;
         2'h2 : att_base_ms = `RATC_ATT_BASE_2;
         2'h3 : att_base_ms = `RATC_ATT_BASE_3;
      endcase
   end

   always_comb begin
      unique case (dec_base_code)
         2'h0 : dec_base_ms = `RATC_DEC_BASE_0;
         2'h1 : dec_base_ms = `RATC_DEC_BASE_1;
         2'h2 : dec_base_ms = `RATC_DEC_BASE_2;
         2'h3 : dec_base_ms = `RATC_DEC_BASE_3;
      endcase
   end

   // widths hold 11 ms x 128 and 350 ms x 128 without overflow
   assign att_scaled_ms = att_base_ms << att_mult_code;
   assign dec_scaled_ms = dec_base_ms << dec_mult_code;

   // ************************************************************
   // decay cap
   // ************************************************************
   ratc_cap ratc_cap_i (
      .ratio_x2 (codec_rate_divider_ratio),
      .cap_ms   (dec_cap_ms)
   );

   // ************************************************************
   // register port
   // ************************************************************
   // reserved low bits are stored as written; software keeps them zero
   always_comb begin
      attack_reg_nxt = attack_reg_r;
      decay_reg_nxt  = decay_reg_r;
      if (reg_wr_en) begin
         if (reg_addr == `RATC_ATTACK_OFS) begin
            attack_reg_nxt = reg_wdata;
         end
         if (reg_addr == `RATC_DECAY_OFS) begin
            decay_reg_nxt = reg_wdata;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         attack_reg_r <= `RATC_ATTACK_RST;
         decay_reg_r  <= `RATC_DECAY_RST;
      end else begin
         attack_reg_r <= attack_reg_nxt;
         decay_reg_r  <= decay_reg_nxt;
      end
   end

   // ************************************************************
   // read port
   // ************************************************************
   // reads see the registers before a write in the same cycle lands
   always_comb begin
      rdata_nxt  = rdata_r;
      rd_ack_nxt = 1'b0;
      if (reg_rd_en) begin
         rd_ack_nxt = 1'b1;
         if (reg_addr == `RATC_ATTACK_OFS) begin
            rdata_nxt = attack_reg_r;
         end else if (reg_addr == `RATC_DECAY_OFS) begin
            rdata_nxt = decay_reg_r;
         end else begin
            rdata_nxt = `RATC_UNMAPPED_RD;
         end
      end
   end

   // read data holds until the next read; the ack is a single pulse
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_r  <= `RATC_RDATA_RST;
         rd_ack_r <= 1'b0;
      end else begin
         rdata_r  <= rdata_nxt;
         rd_ack_r <= rd_ack_nxt;
      end
   end

   // ************************************************************
   // effective times
   // ************************************************************
   // the cap also bounds a legacy decay so the engine never sees more
   // legacy inputs run on clk_sys, so they are read without a synchroniser
   always_comb begin
      att_own_nxt = attack_reg_r[`RATC_SEL_BIT];
      dec_own_nxt = decay_reg_r[`RATC_SEL_BIT];
      if (att_own_nxt) begin
         attack_ms_nxt = att_scaled_ms;
      end else begin
         attack_ms_nxt = legacy_attack_ms;
      end
      if (dec_own_nxt) begin
         dec_chosen_ms = dec_scaled_ms;
      end else begin
         dec_chosen_ms = legacy_decay_ms;
      end
      // live flag, not sticky: it drops once the chosen time fits again
      if (dec_chosen_ms > dec_cap_ms) begin
         decay_ms_nxt = dec_cap_ms;
         capped_nxt   = 1'b1;
      end else begin
         decay_ms_nxt = dec_chosen_ms;
         capped_nxt   = 1'b0;
      end
   end

   // outputs trail the register contents by one edge
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         attack_ms_r <= `RATC_ATT_BASE_0;
         decay_ms_r  <= `RATC_DEC_BASE_0;
         att_own_r   <= 1'b0;
         dec_own_r   <= 1'b0;
         capped_r    <= 1'b0;
      end else begin
         attack_ms_r <= attack_ms_nxt;
         decay_ms_r  <= decay_ms_nxt;
         att_own_r   <= att_own_nxt;
         dec_own_r   <= dec_own_nxt;
         capped_r    <= capped_nxt;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign reg_rdata      = rdata_r;
   assign reg_rd_ack     = rd_ack_r;
   assign attack_time_ms = attack_ms_r;
   assign decay_time_ms  = decay_ms_r;
   assign attack_src_own = att_own_r;
   assign decay_src_own  = dec_own_r;
   assign decay_capped   = capped_r;

endmodule

// File: verif/ratc_regs_props.sv
// checker for the right agc time register pair
// assumes it is bound onto ratc_regs, one clock domain
`timescale 1ns/1ps

module ratc_regs_props (
   // clock and reset
   input wire logic        clk_sys,
   input wire logic        sys_rst,
   // register port
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_wr_en,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_rd_en,
   input wire logic [7:0]  reg_rdata,
   input wire logic        reg_rd_ack,
   // timing
   input wire logic [10:0] legacy_attack_ms,
   input wire logic [15:0] legacy_decay_ms,
   input wire logic [3:0]  codec_rate_divider_ratio,
   input wire logic [10:0] attack_time_ms,
   input wire logic [15:0] decay_time_ms,
   input wire logic        attack_src_own,
   input wire logic        decay_src_own,
   input wire logic        decay_capped
);
   localparam logic [15:0] BASE_C [8] = '{16'h0007, 16'h0008, 16'h000A, 16'h000B,
                                          16'h0032, 16'h0096, 16'h00FA, 16'h015E};
   function automatic logic [15:0] cap_f(logic [3:0] r);
      case (r)
         4'h3: return 16'h15E0;
         4'h4: return 16'h1F40;
         4'h5: return 16'h2580;
         4'h6, 4'h7: return 16'h2BC0;
         4'h8, 4'h9: return 16'h3E80;
         4'hA: return 16'h4B00;
         default: return (r < 4'h3) ? 16'h0FA0 : 16'h5780;
      endcase
   endfunction
   function automatic logic [15:0] lim_f(logic [15:0] v, logic [3:0] r);
      return (v > cap_f(r)) ? cap_f(r) : v;
   endfunction
   function automatic logic [15:0] own_f(logic [7:0] w, logic dec);
      return BASE_C[{dec, w[6:5]}] << w[4:2];
   endfunction
   // ****************
   // properties
   // ****************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // a write lands in two edges: register, then outputs
   sequence att_wr_s;
      reg_wr_en && reg_addr == 8'h69 ##2 1'b1;
   endsequence
   sequence dec_wr_s;
      reg_wr_en && reg_addr == 8'h6A ##2 1'b1;
   endsequence
   att_sel_a: assert property (att_wr_s |-> attack_src_own == $past(reg_wdata[7], 2))
      else $error("attack source not taken from write");
   att_time_a: assert property (att_wr_s ##0 $past(reg_wdata[7], 2) |->
      attack_time_ms == own_f($past(reg_wdata, 2), 1'b0))
      else $error("attack time wrong");
   att_leg_a: assert property (!attack_src_own && !$past(sys_rst) |->
      attack_time_ms == $past(legacy_attack_ms))
      else $error("legacy attack not passed");
   dec_sel_a: assert property (dec_wr_s |-> decay_src_own == $past(reg_wdata[7], 2))
      else $error("decay source not taken from write");
   dec_time_a: assert property (dec_wr_s ##0 $past(reg_wdata[7], 2) |->
      decay_time_ms == lim_f(own_f($past(reg_wdata, 2), 1'b1), $past(codec_rate_divider_ratio)))
      else $error("decay time wrong");
   dec_leg_a: assert property (!decay_src_own && !$past(sys_rst) |->
      decay_time_ms == lim_f($past(legacy_decay_ms), $past(codec_rate_divider_ratio))
      && decay_capped == ($past(legacy_decay_ms) > cap_f($past(codec_rate_divider_ratio))))
      else $error("legacy decay or cap wrong");
   rd_unmap_a: assert property (reg_rd_en && reg_addr != 8'h69 && reg_addr != 8'h6A
      |=> reg_rd_ack && reg_rdata == 8'h00)
      else $error("unmapped read wrong");
   rst_val_a: assert property ($fell(sys_rst) |-> !attack_src_own && !decay_src_own)
      else $error("select bits not clear after reset");
endmodule

bind ratc_regs ratc_regs_props ratc_regs_props_i (.*);

// File: verif/ratc_regs_test.sv
// testbench for the right agc time register pair
// assumes ratc_regs and its checker are compiled alongside
`timescale 1ns/1ps

module ratc_regs_test;
   import ratc_pkg::*;
   logic         clk_sys = 1'b0;
   logic         sys_rst, reg_wr_en, reg_rd_en, reg_rd_ack;
   logic         attack_src_own, decay_src_own, decay_capped;
   ratc_byte_t   reg_addr, reg_wdata, reg_rdata;
   ratc_att_ms_t legacy_attack_ms, attack_time_ms;
   ratc_dec_ms_t legacy_decay_ms, decay_time_ms;
   ratc_ratio_t  codec_rate_divider_ratio;
   int           error_cnt, checked;
   logic [15:0]  e;
   logic [15:0]  capv [16] = '{16'h0FA0, 16'h0FA0, 16'h0FA0, 16'h15E0, 16'h1F40, 16'h2580,
      16'h2BC0, 16'h2BC0, 16'h3E80, 16'h3E80, 16'h4B00, 16'h5780, 16'h5780, 16'h5780,
      16'h5780, 16'h5780};
   logic [15:0]  base [8] = '{16'h0007, 16'h0008, 16'h000A, 16'h000B,
                              16'h0032, 16'h0096, 16'h00FA, 16'h015E};

   ratc_regs ratc_regs_i (.*);

   // ****************
   // access tasks
   // ****************
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input ratc_byte_t a, input ratc_byte_t d);
      @(negedge clk_sys);
      reg_addr = a;
      reg_wdata = d;
      reg_wr_en = 1'b1;
      @(negedge clk_sys);
      reg_wr_en = 1'b0;
      repeat (2) @(negedge clk_sys);
   endtask
   task automatic rd(input ratc_byte_t a, input ratc_byte_t exp);
      @(negedge clk_sys);
      reg_addr = a;
      reg_rd_en = 1'b1;
      @(negedge clk_sys);
      reg_rd_en = 1'b0;
      chk({15'h0, reg_rd_ack}, 16'h1);
      chk({8'h0, reg_rdata}, {8'h0, exp});
   endtask
   task automatic conclude;
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // starts low at declaration so time zero gives no false falling edge
   initial begin
      forever #12.5 clk_sys = ~clk_sys;
   end
   // watchdog at 2000 cycles, about five times the whole run
   initial begin
      #50000;
      error_cnt++;
      conclude();
   end
   initial begin
      sys_rst = 1'b1;
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      legacy_attack_ms = 11'h123;
      legacy_decay_ms = 16'h6000;
      codec_rate_divider_ratio = 4'h4;
      repeat (12) @(negedge clk_sys);
      sys_rst = 1'b0;
      rd(8'h69, 8'h00);
      rd(8'h6A, 8'h00);
      chk(attack_time_ms, 16'h0123);
      chk(decay_time_ms, 16'h1F40);
      chk({attack_src_own, decay_src_own, decay_capped}, 16'h1);
      legacy_decay_ms = 16'h0100;
      @(negedge clk_sys);
      chk(decay_time_ms, 16'h0100);
      for (int i = 0; i < 32; i++) begin
         wr(8'h69, {1'b1, i[4:0], 2'b00});
         chk(attack_time_ms, base[i[4:3]] << i[2:0]);
         chk({15'h0, attack_src_own}, 16'h1);
         rd(8'h69, {1'b1, i[4:0], 2'b00});
      end
      codec_rate_divider_ratio = 4'hC;
      for (int i = 0; i < 32; i++) begin
         wr(8'h6A, {1'b1, i[4:0], 2'b00});
         e = base[{1'b1, i[4:3]}] << i[2:0];
         chk(decay_time_ms, (e > 16'h5780) ? 16'h5780 : e);
         chk({15'h0, decay_capped}, {15'h0, e > 16'h5780});
         chk({15'h0, decay_src_own}, 16'h1);
      end
      // longest own decay against every ratio code
      wr(8'h6A, 8'hFC);
      for (int r = 0; r < 16; r++) begin
         codec_rate_divider_ratio = r[3:0];
         @(negedge clk_sys);
         chk(decay_time_ms, capv[r]);
      end
      // fields left set while the source goes back to legacy
      wr(8'h69, 8'h7C);
      chk(attack_time_ms, 16'h0123);
      wr(8'h6A, 8'h7C);
      chk(decay_time_ms, 16'h0100);
      chk({14'h0, attack_src_own, decay_src_own}, 16'h0);
      wr(8'h6B, 8'hFF);
      rd(8'h6B, 8'h00);
      rd(8'h69, 8'h7C);
      sys_rst = 1'b1;
      @(negedge clk_sys);
      sys_rst = 1'b0;
      rd(8'h69, 8'h00);
      rd(8'h6A, 8'h00);
      conclude();
   end
endmodule
